// >>> inc/cth_pkg.sv
// Package of constants for the per-channel threshold and oversampling register bank
// What this block does
// R1: Standard sequencer: channel 0 high-impedance enable applies to all sixteen inputs.
// R2: Advanced sequencer: each input uses its own high-impedance enable.
// R3: High-impedance enable is read/write, resets to one; one enables it.
// R4: Standard sequencer: channel 0 oversampling field sets ratio for every input.
// R5: Advanced sequencer: each input uses its own oversampling field.
// R6: Codes 0..3 give ratios 1, 4, 16, 64 and 16..19 result bits.
// R7: Host keeps every oversampling field zero while a command mode is on.
// R8: Upper threshold is 12-bit read/write, compared with result's 12 top bits.
// R9: Sixteen 16-bit upper threshold words, two apart, reset field 0x7ff.
// R10: Lower threshold is 12-bit read/write, compared with result's 12 top bits.
// R11: Lower threshold words at 0x060 to 0x07e, each resets to zero.
// R12: Hysteresis is 12-bit read/write, used in that channel's threshold detection.
// R13: Hysteresis words at 0x080 to 0x09e, each resets to 0x0010.
// R14: Alert flags are active only where threshold detection is enabled.
// R15: Reserved bits read zero and ignore writes.
package cth_pkg;
  localparam int NCH = 16;
  localparam int LIM_W = 12;
  // Register indices; byte address is four times the index
  localparam logic [9:0] I_CTRL = 10'h010;
  localparam logic [9:0] I_STS = 10'h011;
  localparam logic [9:0] I_MSK = 10'h012;
  localparam logic [9:0] I_ALR = 10'h013;
  localparam logic [9:0] I_CFG = 10'h030;
  localparam logic [9:0] I_HIGH = 10'h040;
  localparam logic [9:0] I_LOW = 10'h060;
  localparam logic [9:0] I_DB = 10'h080;
  // Field positions
  localparam int CTRL_ADV_BIT = 0;
  localparam int CFG_TD_BIT = 7;
  localparam int CFG_HIZ_BIT = 3;
  localparam int CFG_OSR_LSB = 0;
  // Reset values and writable masks
  localparam logic [7:0] RST_CFG = 8'h08;
  localparam logic [7:0] CFG_WMASK = 8'hfb;
  localparam logic [11:0] RST_HIGH = 12'h7ff;
  localparam logic [11:0] RST_LOW = 12'h000;
  localparam logic [11:0] RST_DB = 12'h010;
  // Oversampling decode
  localparam logic [6:0] RATIO_C0 = 7'h01;
  localparam logic [6:0] RATIO_C1 = 7'h04;
  localparam logic [6:0] RATIO_C2 = 7'h10;
  localparam logic [6:0] RATIO_C3 = 7'h40;
  localparam logic [4:0] BITS_C0 = 5'h10;
  localparam logic [4:0] BITS_C1 = 5'h11;
  localparam logic [4:0] BITS_C2 = 5'h12;
  localparam logic [4:0] BITS_C3 = 5'h13;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/cth_osr_dec.sv
// Oversampling select decoder: ratio and result width
module cth_osr_dec (
  input wire logic [1:0] sel,
  output logic [6:0] ratio,
  output logic [4:0] rbits
);
  // Map the two-bit select onto ratio and widened result size
  always_comb begin
    case (sel) // [R6]
      2'h0: begin
        ratio = cth_pkg::RATIO_C0;
        rbits = cth_pkg::BITS_C0;
      end
      2'h1: begin
        ratio = cth_pkg::RATIO_C1;
        rbits = cth_pkg::BITS_C1;
      end
      2'h2: begin
        ratio = cth_pkg::RATIO_C2;
        rbits = cth_pkg::BITS_C2;
      end
      default: begin
        ratio = cth_pkg::RATIO_C3;
        rbits = cth_pkg::BITS_C3;
      end
    endcase
  end
endmodule

// >>> rtl/cth_limit_det.sv
// One channel's window detector with hysteresis
module cth_limit_det (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en,
  input wire logic hit,
  input wire logic [11:0] code,
  input wire logic [11:0] high,
  input wire logic [11:0] low,
  input wire logic [11:0] db,
  output logic hi_flag,
  output logic lo_flag,
  output logic hi_set,
  output logic lo_set
);
  typedef struct packed {
    logic hi;
    logic lo;
  } cth_det_t;
  cth_det_t s_ff;
  cth_det_t nxt_s;
  logic [12:0] up_clr;
  logic [12:0] lo_clr;

  // Release points; a deadband at least as wide as the upper limit never releases the high flag
  assign up_clr = {1'b0, high} - {1'b0, db};
  assign lo_clr = {1'b0, low} + {1'b0, db};

  // Set on crossing, clear once back past the deadband or when detection is off
  always_comb begin
    nxt_s = s_ff;
    hi_set = 1'b0;
    lo_set = 1'b0;
    if (!en) begin
      nxt_s = '0; // [R14]
    end else if (hit) begin
      if (code > high) begin
        nxt_s.hi = 1'b1; // [R8]
        hi_set = !s_ff.hi;
      end else if (!up_clr[12] && {1'b0, code} < up_clr) begin
        nxt_s.hi = 1'b0; // [R12]
      end
      if (code < low) begin
        nxt_s.lo = 1'b1; // [R10]
        lo_set = !s_ff.lo;
      end else if ({1'b0, code} > lo_clr) begin
        nxt_s.lo = 1'b0; // [R12]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign hi_flag = s_ff.hi;
  assign lo_flag = s_ff.lo;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_high_set: assert property (en && hit && code > high |=> hi_flag) // [R8]
    else $error("high alert not raised above limit");
  chk_low_set: assert property (en && hit && code < low |=> lo_flag) // [R10]
    else $error("low alert not raised below limit");
  chk_deadband_hold: assert property ( // [R12]
    en && hit && hi_flag && {1'b0, code} >= up_clr |=> hi_flag)
    else $error("high alert dropped inside deadband");
  chk_detect_off: assert property (!en |=> !hi_flag && !lo_flag) // [R14]
    else $error("alert active with detection disabled");
endmodule

// >>> rtl/cth_bank.sv
// Channel configuration, threshold and hysteresis register bank with AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite register port.
module cth_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic res_valid,
  input wire logic [3:0] res_chan,
  input wire logic [15:0] res_code,
  output logic [15:0] input_highz_enable,
  output logic [31:0] oversample_ratio_select,
  output logic [6:0] oversample_ratio,
  output logic [4:0] res_bits,
  output logic [15:0] high_alert_flag,
  output logic [15:0] low_alert_flag,
  output logic irq
);
  typedef struct packed {
    logic [15:0][7:0] cfg;
    logic [15:0][11:0] high;
    logic [15:0][11:0] low;
    logic [15:0][11:0] db;
    logic adv;
    logic [31:0] sts;
    logic [31:0] msk;
    logic aw_rdy;
    logic w_rdy;
    logic bvalid;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [9:0] aw_idx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] rdata;
    logic [15:0] hiz;
    logic [31:0] osr;
    logic [6:0] ratio;
    logic [4:0] rbits;
    logic irq;
  } cth_bank_t;

  cth_bank_t s_ff;
  cth_bank_t nxt_s;
  logic [15:0][7:0] eff;
  logic [15:0] limit_detect_enable;
  logic [15:0] hs;
  logic [15:0] ls;
  logic [15:0] hf;
  logic [15:0] lf;
  logic [15:0] own_hiz;
  logic [31:0] own_osr;
  logic [1:0] res_sel;
  logic [6:0] dec_ratio;
  logic [4:0] dec_bits;

  // Reset image of the whole state
  function automatic cth_bank_t rst_val();
    cth_bank_t r;
    r = '0;
    for (int i = 0; i < cth_pkg::NCH; i++) begin
      r.cfg[i] = cth_pkg::RST_CFG; // [R3]
      r.high[i] = cth_pkg::RST_HIGH; // [R9]
      r.low[i] = cth_pkg::RST_LOW; // [R11]
      r.db[i] = cth_pkg::RST_DB; // [R13]
      r.hiz[i] = cth_pkg::RST_CFG[cth_pkg::CFG_HIZ_BIT];
    end
    r.aw_rdy = 1'b1;
    r.w_rdy = 1'b1;
    r.ar_rdy = 1'b1;
    return r;
  endfunction

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] bmask(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  // Merge written lanes into an old value
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                      input logic [31:0] m);
    return (o & ~m) | (d & m);
  endfunction

  // Read mux; bit 32 flags an unmapped index. Upper bits stay zero except in the status, mask and alert words.
  function automatic logic [32:0] rd_word(input logic [9:0] i, input cth_bank_t s,
                                          input logic [15:0] h, input logic [15:0] l);
    logic [32:0] r;
    r = 33'h0;
    if (i[9:4] == cth_pkg::I_CFG[9:4]) begin
      r[7:0] = s.cfg[i[3:0]]; // [R15]
    end else if (i[9:5] == cth_pkg::I_HIGH[9:5] && !i[0]) begin
      r[11:0] = s.high[i[4:1]]; // [R8] [R15]
    end else if (i[9:5] == cth_pkg::I_LOW[9:5] && !i[0]) begin
      r[11:0] = s.low[i[4:1]]; // [R10]
    end else if (i[9:5] == cth_pkg::I_DB[9:5] && !i[0]) begin
      r[11:0] = s.db[i[4:1]]; // [R12]
    end else if (i == cth_pkg::I_CTRL) begin
      r[cth_pkg::CTRL_ADV_BIT] = s.adv;
    end else if (i == cth_pkg::I_STS) begin
      r[31:0] = s.sts;
    end else if (i == cth_pkg::I_MSK) begin
      r[31:0] = s.msk;
    end else if (i == cth_pkg::I_ALR) begin
      r[31:0] = {l, h};
    end else begin
      r[32] = 1'b1;
    end
    return r;
  endfunction

  // Settings in force per input: channel 0 for all, or each its own
  always_comb begin
    for (int i = 0; i < cth_pkg::NCH; i++) begin
      eff[i] = s_ff.adv ? s_ff.cfg[i] : s_ff.cfg[0]; // [R1] [R2] [R4] [R5]
      limit_detect_enable[i] = eff[i][cth_pkg::CFG_TD_BIT]; // [R14]
      own_hiz[i] = s_ff.cfg[i][cth_pkg::CFG_HIZ_BIT];
      own_osr[2*i +: 2] = s_ff.cfg[i][cth_pkg::CFG_OSR_LSB +: 2];
    end
  end

  // Ratio for the channel whose result is arriving
  assign res_sel = eff[res_chan][cth_pkg::CFG_OSR_LSB +: 2];

  cth_osr_dec u_dec (
    .sel(res_sel),
    .ratio(dec_ratio),
    .rbits(dec_bits)
  );

  // One detector per input; results carry the 12 top bits to compare
  for (genvar g = 0; g < cth_pkg::NCH; g++) begin : g_det
    cth_limit_det u_det (
      .aclk(aclk),
      .aresetn(aresetn),
      .en(limit_detect_enable[g]),
      .hit(res_valid && res_chan == 4'(g)),
      .code(res_code[15:4]),
      .high(s_ff.high[g]),
      .low(s_ff.low[g]),
      .db(s_ff.db[g]),
      .hi_flag(hf[g]),
      .lo_flag(lf[g]),
      .hi_set(hs[g]),
      .lo_set(ls[g])
    );
  end

  // Next state: bus handshake, register writes, events and outputs
  always_comb begin
    logic [32:0] rw;
    logic [31:0] m;
    logic [31:0] w32;
    logic [31:0] clr;
    logic [9:0] wi;
    logic [3:0] c;
    rw = 33'h0;
    m = 32'h0;
    w32 = 32'h0;
    clr = 32'h0;
    wi = s_ff.aw_idx;
    c = wi[4:1];
    nxt_s = s_ff;
    // Address and data may arrive in either order
    if (awvalid && s_ff.aw_rdy) begin
      nxt_s.aw_rdy = 1'b0;
      nxt_s.aw_idx = awaddr[11:2];
    end
    if (wvalid && s_ff.w_rdy) begin
      nxt_s.w_rdy = 1'b0;
      nxt_s.wdata = wdata;
      nxt_s.wstrb = wstrb;
    end
    // Both halves held: commit once and answer
    if (!s_ff.aw_rdy && !s_ff.w_rdy && !s_ff.bvalid) begin
      m = bmask(s_ff.wstrb);
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = cth_pkg::RESP_OKAY;
      if (wi[9:4] == cth_pkg::I_CFG[9:4]) begin
        w32 = mrg({24'h0, s_ff.cfg[wi[3:0]]}, s_ff.wdata, m);
        nxt_s.cfg[wi[3:0]] = w32[7:0] & cth_pkg::CFG_WMASK; // [R3] [R15]
      end else if (wi[9:5] == cth_pkg::I_HIGH[9:5] && !wi[0]) begin
        w32 = mrg({20'h0, s_ff.high[c]}, s_ff.wdata, m);
        nxt_s.high[c] = w32[11:0]; // [R8] [R15]
      end else if (wi[9:5] == cth_pkg::I_LOW[9:5] && !wi[0]) begin
        w32 = mrg({20'h0, s_ff.low[c]}, s_ff.wdata, m);
        nxt_s.low[c] = w32[11:0]; // [R10]
      end else if (wi[9:5] == cth_pkg::I_DB[9:5] && !wi[0]) begin
        w32 = mrg({20'h0, s_ff.db[c]}, s_ff.wdata, m);
        nxt_s.db[c] = w32[11:0]; // [R12]
      end else if (wi == cth_pkg::I_CTRL) begin
        w32 = mrg({31'h0, s_ff.adv}, s_ff.wdata, m);
        nxt_s.adv = w32[cth_pkg::CTRL_ADV_BIT];
      end else if (wi == cth_pkg::I_STS) begin
        clr = s_ff.wdata & m;
      end else if (wi == cth_pkg::I_MSK) begin
        nxt_s.msk = mrg(s_ff.msk, s_ff.wdata, m);
      end else if (wi != cth_pkg::I_ALR) begin
        nxt_s.bresp = cth_pkg::RESP_SLVERR;
      end
    end
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
      nxt_s.aw_rdy = 1'b1;
      nxt_s.w_rdy = 1'b1;
    end
    // Reads answer one cycle after the address is taken
    if (arvalid && s_ff.ar_rdy) begin
      rw = rd_word(araddr[11:2], s_ff, hf, lf);
      nxt_s.ar_rdy = 1'b0;
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rw[31:0];
      nxt_s.rresp = rw[32] ? cth_pkg::RESP_SLVERR : cth_pkg::RESP_OKAY;
    end
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
      nxt_s.ar_rdy = 1'b1;
    end
    // Sticky alert events; a new event beats a same-cycle clear
    nxt_s.sts = (s_ff.sts & ~clr) | {ls, hs};
    nxt_s.irq = |(nxt_s.sts & nxt_s.msk);
    // Per-input settings in force
    for (int i = 0; i < cth_pkg::NCH; i++) begin
      nxt_s.hiz[i] = eff[i][cth_pkg::CFG_HIZ_BIT]; // [R1] [R2]
      nxt_s.osr[2*i +: 2] = eff[i][cth_pkg::CFG_OSR_LSB +: 2]; // [R4] [R5]
    end
    // Result format follows the arriving channel's ratio
    if (res_valid) begin
      nxt_s.ratio = dec_ratio; // [R6]
      nxt_s.rbits = dec_bits;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= rst_val();
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Ports straight from state flops
  assign awready = s_ff.aw_rdy;
  assign wready = s_ff.w_rdy;
  assign bvalid = s_ff.bvalid;
  assign bresp = s_ff.bresp;
  assign arready = s_ff.ar_rdy;
  assign rvalid = s_ff.rvalid;
  assign rdata = s_ff.rdata;
  assign rresp = s_ff.rresp;
  assign input_highz_enable = s_ff.hiz;
  assign oversample_ratio_select = s_ff.osr;
  assign oversample_ratio = s_ff.ratio;
  assign res_bits = s_ff.rbits;
  assign high_alert_flag = hf;
  assign low_alert_flag = lf;
  assign irq = s_ff.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_held;
    !s_ff.aw_rdy && !s_ff.w_rdy && !s_ff.bvalid;
  endsequence

  sequence s_wr_done;
    ##1 s_ff.bvalid ##0 (s_ff.aw_rdy == 1'b0);
  endsequence

  sequence s_res_top;
    res_valid && res_sel == 2'h3;
  endsequence

  sequence s_rd_taken;
    arvalid && s_ff.ar_rdy;
  endsequence

  chk_reset_values: assert property ($rose(aresetn) |-> // [R3] [R9] [R11] [R13]
    s_ff.cfg[5] == 8'h08 && s_ff.high[3] == 12'h7ff && s_ff.low[7] == 12'h000
    && s_ff.db[15] == 12'h010 && input_highz_enable == 16'hffff)
    else $error("register reset value wrong");
  chk_highz_std: assert property (!s_ff.adv |=> // [R1]
    input_highz_enable == {16{$past(s_ff.cfg[0][3])}})
    else $error("standard mode high-z not from channel 0");
  chk_highz_adv: assert property (s_ff.adv |=> input_highz_enable == $past(own_hiz)) // [R2]
    else $error("advanced mode high-z not per channel");
  chk_osr_std: assert property (!s_ff.adv |=> // [R4]
    oversample_ratio_select == {16{$past(s_ff.cfg[0][1:0])}})
    else $error("standard mode ratio not from channel 0");
  chk_osr_adv: assert property (s_ff.adv |=> oversample_ratio_select == $past(own_osr)) // [R5]
    else $error("advanced mode ratio not per channel");
  chk_osr_decode: assert property (s_res_top |=> // [R6]
    oversample_ratio == 7'h40 && res_bits == 5'h13)
    else $error("ratio code 3 not decoded to 64 and 19 bits");
  // Only the per-channel words; status and alert words fill their upper half
  chk_resv_zero: assert property (s_rd_taken ##0 (araddr[11:2] >= cth_pkg::I_CFG // [R15]
    && araddr[11:2] < cth_pkg::I_DB + 10'h020) |=> s_ff.rdata[31:12] == 20'h0
    && !s_ff.cfg[0][2] && !s_ff.cfg[9][2])
    else $error("reserved bits not zero");
  // Odd indices between the upper limit words are holes in the map
  chk_read_hole: assert property (s_rd_taken ##0 araddr[2] // [R9]
    && araddr[11:7] == cth_pkg::I_HIGH[9:5]
    |=> s_ff.rresp == cth_pkg::RESP_SLVERR && s_ff.rdata == 32'h0)
    else $error("hole between upper limit words answered");
  // A committed configuration write never stores the reserved bit
  chk_cfg_resv: assert property (s_wr_held ##0 s_ff.aw_idx[9:4] == cth_pkg::I_CFG[9:4] // [R15]
    |=> !s_ff.cfg[$past(s_ff.aw_idx[3:0])][2])
    else $error("reserved configuration bit stored");
  chk_write_answer: assert property (s_wr_held |-> s_wr_done)
    else $error("write response missing");
  // A taken read answers on the next edge and blocks further addresses
  chk_read_answer: assert property (s_rd_taken |=> s_ff.rvalid && !s_ff.ar_rdy)
    else $error("read answer missing");
  // Standard scope: channel 0 switching detection off silences every input
  chk_detect_std: assert property (!s_ff.adv && !s_ff.cfg[0][cth_pkg::CFG_TD_BIT] |=> // [R14]
    high_alert_flag == 16'h0 && low_alert_flag == 16'h0)
    else $error("alert active with channel 0 detection off");
  // Ratio and width describe the last result and hold between results
  chk_ratio_hold: assert property (!res_valid |=> // [R6]
    $stable(oversample_ratio) && $stable(res_bits))
    else $error("ratio changed without a result");
  // A new alert event must survive a clear written in the same cycle
  chk_status_sticky: assert property (|{ls, hs} |=>
    (s_ff.sts & $past({ls, hs})) == $past({ls, hs}))
    else $error("alert event lost in status");
  // Interrupt level tracks masked status with no extra delay
  chk_irq_level: assert property (irq == |(s_ff.sts & s_ff.msk))
    else $error("interrupt does not follow masked status");
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the channel threshold and oversampling register bank
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic res_valid = 1'b0;
  logic [3:0] res_chan = 4'h0;
  logic [15:0] res_code = 16'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, oversample_ratio_select;
  logic [15:0] input_highz_enable, high_alert_flag, low_alert_flag;
  logic [6:0] oversample_ratio;
  logic [4:0] res_bits;
  int err_count = 0;
  int cmp_count = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [15:0] exph;
  logic [31:0] expo, v;
  logic [7:0] c;

  cth_bank cth_bank_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .res_valid(res_valid), .res_chan(res_chan), .res_code(res_code),
    .input_highz_enable(input_highz_enable), .oversample_ratio_select(oversample_ratio_select),
    .oversample_ratio(oversample_ratio), .res_bits(res_bits), .high_alert_flag(high_alert_flag),
    .low_alert_flag(low_alert_flag), .irq(irq));

  // 20 MHz clock
  always #25 aclk = ~aclk;

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Byte addresses: the register index times four
  function automatic logic [11:0] cfg_a(input int n);
    return 12'h0c0 + 12'(4 * n);
  endfunction
  function automatic logic [11:0] lim_a(input int t, input int n);
    return 12'h100 + 12'(t * 12'h080) + 12'(8 * n);
  endfunction

  // Both channels offered together and released each as it is taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
    bit done;
    done = 0;
    bq.push_back(resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) done = 1;
    end
    bready <= 1'b0;
    if (!done) begin
      err_count++;
      final_report;
    end
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
    bit done;
    done = 0;
    rq.push_back({resp, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) done = 1;
    end
    rready <= 1'b0;
    if (!done) begin
      err_count++;
      final_report;
    end
  endtask

  // One result pulse on a channel
  task automatic result(input logic [3:0] ch, input logic [15:0] code);
    @(posedge aclk);
    res_valid <= 1'b1;
    res_chan <= ch;
    res_code <= code;
    @(posedge aclk);
    res_valid <= 1'b0;
  endtask

  // Settings outputs lag a register change by one edge, so give them two
  task automatic settle;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Answers are taken from the oldest note as they are handed over
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready) begin
      if (rq.size() == 0) begin
        err_count++;
        $display("[FAIL] %0t ns: read answer with no request", $time);
      end else check({rresp, rdata}, rq.pop_front());
    end
    if (bvalid === 1'b1 && bready) begin
      if (bq.size() == 0) begin
        err_count++;
        $display("[FAIL] %0t ns: write answer with no request", $time);
      end else check({32'h0, bresp}, {32'h0, bq.pop_front()});
    end
  end

  initial begin
    void'($urandom(78));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check({18'h0, input_highz_enable}, {18'h0, 16'hffff});
    check({2'h0, oversample_ratio_select}, 34'h0);
    for (int n = 0; n < 16; n++) begin
      axi_rd(cfg_a(n), 32'h08, 2'h0);
      axi_rd(lim_a(0, n), 32'h7ff, 2'h0);
      axi_rd(lim_a(1, n), 32'h0, 2'h0);
      axi_rd(lim_a(2, n), 32'h10, 2'h0);
    end
    $display("Test reset_values done");

    // Reserved bits and random limit values round trip
    axi_wr(cfg_a(7), 32'hffffffff, 2'h0);
    axi_rd(cfg_a(7), 32'hfb, 2'h0);
    for (int t = 0; t < 3; t++) begin
      for (int n = 0; n < 16; n++) begin
        v = $urandom;
        axi_wr(lim_a(t, n), v, 2'h0);
        axi_rd(lim_a(t, n), {20'h0, v[11:0]}, 2'h0);
      end
    end
    axi_rd(12'h104, 32'h0, 2'h2);
    axi_wr(12'h104, 32'h5a5, 2'h2);
    $display("Test access_kinds done");

    // Standard sequencer: channel 0 rules all inputs
    axi_wr(cfg_a(0), 32'h02, 2'h0);
    axi_wr(cfg_a(5), 32'h0b, 2'h0);
    settle;
    check({18'h0, input_highz_enable}, 34'h0);
    check({2'h0, oversample_ratio_select}, {2'h0, 32'haaaaaaaa});
    $display("Test standard_scope done");

    // Advanced sequencer: each input its own settings
    axi_wr(12'h040, 32'h1, 2'h0);
    for (int n = 0; n < 16; n++) begin
      c = 8'($urandom) & 8'h7f; // Any ratio code: no command mode is ever on
      axi_wr(cfg_a(n), {24'h0, c}, 2'h0);
      exph[n] = c[3];
      expo[2*n+:2] = c[1:0];
    end
    settle;
    check({18'h0, input_highz_enable}, {18'h0, exph});
    check({2'h0, oversample_ratio_select}, {2'h0, expo});
    for (int k = 0; k < 4; k++) begin
      axi_wr(cfg_a(3), 32'h08 | k, 2'h0);
      result(4'h3, 16'h1230);
      settle;
      check({27'h0, oversample_ratio}, {27'h0, 7'h01 << (2 * k)});
      check({29'h0, res_bits}, 34'(16 + k));
    end
    $display("Test advanced_scope done");

    // Alerts with hysteresis, status, mask and disable
    axi_wr(12'h044, 32'hffffffff, 2'h0);
    axi_wr(lim_a(0, 2), 32'h7ff, 2'h0);
    axi_wr(lim_a(1, 2), 32'h100, 2'h0);
    axi_wr(lim_a(2, 2), 32'h010, 2'h0);
    axi_wr(lim_a(0, 4), 32'h7ff, 2'h0);
    axi_wr(cfg_a(2), 32'h88, 2'h0);
    axi_wr(cfg_a(4), 32'h08, 2'h0);
    result(4'h2, 16'h8000);
    result(4'h4, 16'hfff0);
    settle;
    check({18'h0, high_alert_flag}, {18'h0, 16'h0004});
    check({33'h0, irq}, 34'h0);
    axi_rd(12'h044, 32'h4, 2'h0);
    axi_wr(12'h048, 32'h4, 2'h0);
    settle;
    check({33'h0, irq}, 34'h1);
    result(4'h2, 16'h7f00);
    settle;
    check({18'h0, high_alert_flag}, {18'h0, 16'h0004});
    result(4'h2, 16'h7e00);
    settle;
    check({18'h0, high_alert_flag}, 34'h0);
    axi_wr(12'h044, 32'h4, 2'h0);
    settle;
    check({33'h0, irq}, 34'h0);
    axi_rd(12'h044, 32'h0, 2'h0);
    result(4'h2, 16'h0ff0);
    settle;
    check({18'h0, low_alert_flag}, {18'h0, 16'h0004});
    axi_rd(12'h044, 32'h00040000, 2'h0);
    axi_wr(12'h04c, 32'h0, 2'h0);
    axi_rd(12'h04c, 32'h00040000, 2'h0);
    axi_wr(cfg_a(2), 32'h08, 2'h0);
    settle;
    check({18'h0, low_alert_flag}, 34'h0);
    $display("Test alerts done");
    repeat (3) @(posedge aclk);
    if (rq.size() != 0 || bq.size() != 0) err_count++;
    final_report;
  end
endmodule
